// ==== rtl/sloc_pkg.sv ====
// Constants shared by the overhead control block and its helpers
//
// Notes on behaviour
// - Writing force-reframe pushes the framer out of frame at next boundary.
// - Descrambler-off passes received bytes without descrambling.
// - Block mode counts one per errored B1 byte, else every bit.
// - Section status shows live out-of-frame, frame-loss, signal-loss in bits 0-2.
// - Any change of those three states sets its event; status read clears.
// - Any B1 bit error sets the parity event; status read clears it.
// - A 16-bit readable B1 error count holds errors since last poll.
// - Writing a count address polls; count moves and restarts, nothing lost.
// - Writing the master address also polls every counter.
// - Writing the channel interrupt status address also polls every counter.
// - Line alarm insert sends ones outside section overhead, frame aligned.
// - Scrambler-off sends the transmit stream unscrambled.
// - Framing diag sends A1 as 76h; parity diag inverts every B1.
// - All-zero diag forces every transmitted byte to zero.
// - Line status shows live line alarm in bit 1, remote defect bit 0.
// - Far-error word mode counts once per errored frame, else every bit.
// - B2 report word mode gives one per errored frame, else per bit.
// - Remote defect declared after 110 in K2 for three or five frames.
// - Line alarm declared after 111 in K2 for three or five frames.
// - Force-ones makes downstream data all ones while line alarm declared.
// - B2 word mode counts once per errored frame, else every bit.
// - Line events set on alarm changes, B2 and far-end errors; read clears.
// - Section events reach the interrupt output only when enabled.
// - Line events reach the interrupt output only when enabled.
package sloc_pkg;

   // Register offsets
   localparam logic [7:0] ADR_MASTER     = 8'h00;
   localparam logic [7:0] ADR_CH_IRQ     = 8'h07;
   localparam logic [7:0] ADR_SEC_CTRL   = 8'h10;
   localparam logic [7:0] ADR_SEC_STATUS = 8'h11;
   localparam logic [7:0] ADR_SEC_CNT_LO = 8'h12;
   localparam logic [7:0] ADR_SEC_CNT_HI = 8'h13;
   localparam logic [7:0] ADR_TX_CTRL    = 8'h14;
   localparam logic [7:0] ADR_TX_DIAG    = 8'h15;
   localparam logic [7:0] ADR_LINE_CTRL  = 8'h18;
   localparam logic [7:0] ADR_LINE_IRQ   = 8'h19;

   // Section control field positions
   localparam int SC_BLOCK_MODE = 7;
   localparam int SC_DESCR_OFF  = 6;
   localparam int SC_REFRAME    = 5;
   localparam int SC_ALGO2      = 4;
   localparam int SC_EN_HI      = 3;

   // Section event positions (within the 4-bit event vector)
   localparam int SEV_OOF = 0;
   localparam int SEV_LOF = 1;
   localparam int SEV_LOS = 2;
   localparam int SEV_BIP = 3;

   // Transmit control and diagnostic positions
   localparam int TC_SCR_OFF   = 6;
   localparam int TC_LINE_AIS  = 0;
   localparam int TD_ALL_ZERO  = 2;
   localparam int TD_B1_INVERT = 1;
   localparam int TD_A1_ERROR  = 0;

   // Line control positions
   localparam int LC_B2_WORD    = 7;
   localparam int LC_FORCE_ONES = 6;
   localparam int LC_AIS_SHORT  = 5;
   localparam int LC_RDI_SHORT  = 4;
   localparam int LC_RPT_WORD   = 3;
   localparam int LC_FEBE_WORD  = 2;

   // Line event positions
   localparam int LEV_RDI  = 0;
   localparam int LEV_AIS  = 1;
   localparam int LEV_B2   = 2;
   localparam int LEV_FEBE = 3;

   // Reset values
   localparam logic [7:0] SEC_CTRL_RST  = 8'h00;
   localparam logic [7:0] TX_CTRL_RST   = 8'h00;
   localparam logic [7:0] TX_DIAG_RST   = 8'h00;
   localparam logic [7:0] LINE_CTRL_RST = 8'h00;
   localparam logic [3:0] LINE_EN_RST   = 4'h0;

   // Stream constants
   localparam logic [7:0] A1_NORMAL  = 8'hF6;
   localparam logic [7:0] A1_ERROR   = 8'h76;
   localparam logic [7:0] BYTE_ONES  = 8'hFF;
   localparam logic [7:0] BYTE_ZERO  = 8'h00;
   localparam logic [2:0] K2_RDI     = 3'h6;
   localparam logic [2:0] K2_AIS     = 3'h7;
   localparam logic [6:0] SCR_SEED   = 7'h7F;
   localparam logic [2:0] PERSIST_SHORT = 3'h3;
   localparam logic [2:0] PERSIST_LONG  = 3'h5;

   // Counter widths
   localparam int SEC_CNT_W  = 16;
   localparam int LINE_CNT_W = 20;

   // Poll transfer time
   localparam int CLK_PERIOD_NS = 10;
   localparam int POLL_MAX_NS   = 7000;
   localparam int POLL_MAX_CYC  = POLL_MAX_NS / CLK_PERIOD_NS;

endpackage

// ==== rtl/sloc_err_counter.sv ====
// Error accumulator with poll transfer to a held readable count
`timescale 1ns/1ns
module sloc_err_counter
   import sloc_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   // Increment
   input  wire logic             incValid,
   input  wire logic [4:0]       incAmount,
   // Poll
   input  wire logic             pollReq,
   output logic                  pollDone,
   output logic [WIDTH-1:0]      heldCount
);

   logic [WIDTH-1:0] acc_q;
   logic [WIDTH-1:0] incWide;

   assign incWide = incValid ? WIDTH'(incAmount) : '0;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         acc_q <= '0;
      end else if (pollReq) begin
         acc_q <= incWide;
      end else begin
         acc_q <= acc_q + incWide;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         heldCount <= '0;
         pollDone  <= 1'b0;
      end else begin
         pollDone <= pollReq;
         if (pollReq) begin
            heldCount <= acc_q;
         end
      end
   end

   localparam int PollLimit = POLL_MAX_CYC;

   a_poll_moves: assert property (@(posedge clk_sys) disable iff (!rst_b)
      pollReq |=> heldCount == $past(acc_q))
      else $error("poll did not move the count");
   a_poll_bound: assert property (@(posedge clk_sys) disable iff (!rst_b)
      pollReq |-> ##[1:PollLimit] pollDone)
      else $error("poll transfer late");
   a_poll_restart: assert property (@(posedge clk_sys) disable iff (!rst_b)
      pollReq |=> acc_q == $past(incWide))
      else $error("coincident error lost at poll");

endmodule

// ==== rtl/sloc_persist_det.sv ====
// Consecutive-frame persistence detector for a K2 pattern
`timescale 1ns/1ns
module sloc_persist_det
   import sloc_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // Frame samples
   input  wire logic frameValid,
   input  wire logic patternHit,
   input  wire logic shortSelect,
   // State
   output logic      declared
);

   logic [2:0] runCnt_q;
   logic [2:0] target;

   assign target = shortSelect ? PERSIST_SHORT : PERSIST_LONG;

   // persistence count
   // Run restarts as the state flips, so removal needs a full run too
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         runCnt_q <= 3'h0;
      end else if (frameValid) begin
         if (patternHit != declared && runCnt_q + 3'h1 < target) begin
            runCnt_q <= runCnt_q + 3'h1;
         end else begin
            runCnt_q <= 3'h0;
         end
      end
   end

   // declare and remove after the same persistence
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         declared <= 1'b0;
      end else if (frameValid && patternHit != declared
                   && runCnt_q + 3'h1 >= target) begin
         declared <= patternHit;
      end
   end

   a_declare_run: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(declared) |-> $past(runCnt_q) + 3'h1 >= $past(target))
      else $error("alarm declared before persistence");
   a_declare_hit: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(declared) |-> $past(patternHit && frameValid))
      else $error("alarm declared without pattern");

endmodule

// ==== rtl/sloc_overhead_ctrl.sv ====
// Section and line overhead control, status and error accounting
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
module sloc_overhead_ctrl
   import sloc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // Register port
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic [7:0]      regRdData,
   // Receive framer state
   input  wire logic       rxOofIn,
   input  wire logic       rxLofIn,
   input  wire logic       rxLosIn,
   output logic            forceReframe,
   output logic            framerAlgo2,
   // Receive stream
   input  wire logic [7:0] rxByteIn,
   input  wire logic       rxValid,
   input  wire logic       rxFrameStart,
   output logic [7:0]      rxDataOut,
   output logic            rxDataValid,
   // Receive error checks
   input  wire logic [7:0] b1ErrMask,
   input  wire logic       b1ErrValid,
   input  wire logic [4:0] b2ErrBits,
   input  wire logic       b2ErrValid,
   input  wire logic [4:0] febeBits,
   input  wire logic       febeValid,
   input  wire logic [7:0] k2Byte,
   input  wire logic       k2Valid,
   // Report to transmit line processor
   output logic [4:0]      b2ReportCount,
   output logic            b2ReportValid,
   // Line error counts
   output logic [19:0]     lineB2Count,
   output logic [19:0]     lineFebeCount,
   // Transmit stream
   input  wire logic [7:0] txByteIn,
   input  wire logic       txValid,
   input  wire logic       txFrameStart,
   input  wire logic       txIsSoh,
   input  wire logic       txIsA1,
   input  wire logic       txIsB1,
   output logic [7:0]      txByteOut,
   output logic            txByteValid,
   // Alarm output
   output logic            irqOut
);

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   // Bit count as given, or one for any, per word mode
   function automatic logic [4:0] errInc(input logic [4:0] bits,
                                         input logic       wordMode);
      errInc = wordMode ? {4'h0, |bits} : bits;
   endfunction

   function automatic logic [4:0] popCount(input logic [7:0] v);
      logic [4:0] n;
      n = 5'h0;
      for (int i = 0; i < 8; i++) begin
         n = n + {4'h0, v[i]};
      end
      popCount = n;
   endfunction

   // One byte of frame-synchronous scrambler key, x^7 + x^6 + 1
   function automatic logic [14:0] scrStep(input logic [6:0] st);
      logic [6:0] s;
      logic [7:0] key;
      s   = st;
      key = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         key[i] = s[6];
         s      = {s[5:0], s[6] ^ s[5]};
      end
      scrStep = {s, key};
   endfunction

   // Register decode
   logic wrSecCtrl;
   logic wrTxCtrl;
   logic wrTxDiag;
   logic wrLineCtrl;
   logic wrLineIrq;
   logic rdSecStatus;
   logic rdLineIrq;
   logic secPoll;
   logic linePoll;

   assign wrSecCtrl   = regWr && regAddr == ADR_SEC_CTRL;
   assign wrTxCtrl    = regWr && regAddr == ADR_TX_CTRL;
   assign wrTxDiag    = regWr && regAddr == ADR_TX_DIAG;
   assign wrLineCtrl  = regWr && regAddr == ADR_LINE_CTRL;
   assign wrLineIrq   = regWr && regAddr == ADR_LINE_IRQ;
   assign rdSecStatus = regRd && regAddr == ADR_SEC_STATUS;
   assign rdLineIrq   = regRd && regAddr == ADR_LINE_IRQ;

   // channel interrupt status write polls all counters
   assign linePoll = regWr && (regAddr == ADR_MASTER
                               || regAddr == ADR_CH_IRQ);
   assign secPoll  = linePoll
                     || (regWr && (regAddr == ADR_SEC_CNT_LO
                                   || regAddr == ADR_SEC_CNT_HI));

   // Control registers
   logic [7:0] secCtrl_q;
   logic [7:0] txCtrl_q;
   logic [2:0] txDiag_q;
   logic [5:0] lineCtrl_q;
   logic [3:0] lineEn_q;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         secCtrl_q  <= SEC_CTRL_RST;
         txCtrl_q   <= TX_CTRL_RST;
         txDiag_q   <= TX_DIAG_RST[2:0];
         lineCtrl_q <= LINE_CTRL_RST[7:2];
         lineEn_q   <= LINE_EN_RST;
      end else begin
         if (wrSecCtrl) begin
            secCtrl_q <= regWrData & ~(8'h01 << SC_REFRAME);
         end
         if (wrTxCtrl) begin
            txCtrl_q <= regWrData & 8'h7F;
         end
         if (wrTxDiag) begin
            txDiag_q <= regWrData[2:0];
         end
         if (wrLineCtrl) begin
            lineCtrl_q <= regWrData[7:2];
         end
         if (wrLineIrq) begin
            lineEn_q <= regWrData[7:4];
         end
      end
   end

   logic blockMode;
   logic descrOff;
   logic scrOff;
   logic lineAisIns;
   logic forceOnes;

   assign blockMode  = secCtrl_q[SC_BLOCK_MODE];
   assign descrOff   = secCtrl_q[SC_DESCR_OFF];
   assign scrOff     = txCtrl_q[TC_SCR_OFF];
   assign lineAisIns = txCtrl_q[TC_LINE_AIS];
   assign forceOnes  = lineCtrl_q[LC_FORCE_ONES - 2];

   // reframe request held until the frame boundary
   logic reframePend_q;
   logic rxBoundary;

   assign rxBoundary = rxValid && rxFrameStart;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         reframePend_q <= 1'b0;
         forceReframe  <= 1'b0;
         framerAlgo2   <= 1'b0;
      end else begin
         reframePend_q <= (wrSecCtrl && regWrData[SC_REFRAME])
                          || (reframePend_q && !rxBoundary);
         forceReframe  <= reframePend_q && rxBoundary;
         framerAlgo2   <= secCtrl_q[SC_ALGO2];
      end
   end

   sequence sReframeArmed;
      reframePend_q ##0 rxBoundary;
   endsequence

   a_reframe_edge: assert property (sReframeArmed |=> forceReframe)
      else $error("reframe not forced at boundary");

   // Framer state tracking and section events
   logic [2:0] frmState_q;
   logic [3:0] secEv_q;
   logic [3:0] secSet;
   logic       b1Any;

   assign b1Any  = b1ErrValid && (|b1ErrMask);
   assign secSet = {b1Any, {rxLosIn, rxLofIn, rxOofIn} ^ frmState_q};

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         frmState_q <= 3'h0;
      end else begin
         frmState_q <= {rxLosIn, rxLofIn, rxOofIn};
      end
   end

   // set wins over the read clear
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         secEv_q <= 4'h0;
      end else begin
         secEv_q <= (secEv_q & {4{!rdSecStatus}}) | secSet;
      end
   end

   a_oof_event: assert property
      ((rxOofIn != frmState_q[SEV_OOF]) |=> secEv_q[SEV_OOF])
      else $error("out-of-frame change lost");
   a_b1_event: assert property (b1Any |=> secEv_q[SEV_BIP])
      else $error("B1 error event lost");

   logic [15:0] secCount;

   sloc_err_counter #(
      .WIDTH(SEC_CNT_W)
   ) uSecCnt (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .incValid  (b1ErrValid),
      .incAmount (blockMode ? {4'h0, |b1ErrMask} : popCount(b1ErrMask)),
      .pollReq   (secPoll),
      .pollDone  (),
      .heldCount (secCount)
   );

   logic rdiState;
   logic aisState;

   sloc_persist_det uRdiDet (
      .clk_sys     (clk_sys),
      .rst_b       (rst_b),
      .frameValid  (k2Valid),
      .patternHit  (k2Byte[2:0] == K2_RDI),
      .shortSelect (lineCtrl_q[LC_RDI_SHORT - 2]),
      .declared    (rdiState)
   );

   sloc_persist_det uAisDet (
      .clk_sys     (clk_sys),
      .rst_b       (rst_b),
      .frameValid  (k2Valid),
      .patternHit  (k2Byte[2:0] == K2_AIS),
      .shortSelect (lineCtrl_q[LC_AIS_SHORT - 2]),
      .declared    (aisState)
   );

   sloc_err_counter #(
      .WIDTH(LINE_CNT_W)
   ) uB2Cnt (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .incValid  (b2ErrValid),
      .incAmount (errInc(b2ErrBits, lineCtrl_q[LC_B2_WORD - 2])),
      .pollReq   (linePoll),
      .pollDone  (),
      .heldCount (lineB2Count)
   );

   sloc_err_counter #(
      .WIDTH(LINE_CNT_W)
   ) uFebeCnt (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .incValid  (febeValid),
      .incAmount (errInc(febeBits, lineCtrl_q[LC_FEBE_WORD - 2])),
      .pollReq   (linePoll),
      .pollDone  (),
      .heldCount (lineFebeCount)
   );

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         b2ReportCount <= 5'h0;
         b2ReportValid <= 1'b0;
      end else begin
         b2ReportValid <= b2ErrValid;
         b2ReportCount <= b2ErrValid
            ? errInc(b2ErrBits, lineCtrl_q[LC_RPT_WORD - 2]) : 5'h0;
      end
   end

   a_report_word: assert property (b2ErrValid
      && lineCtrl_q[LC_RPT_WORD - 2] && |b2ErrBits
      |=> b2ReportCount == 5'h1)
      else $error("word report not one per frame");

   // Line events
   logic       rdiPrev_q;
   logic       aisPrev_q;
   logic [3:0] lineEv_q;
   logic [3:0] lineSet;

   assign lineSet = {febeValid && |febeBits, b2ErrValid && |b2ErrBits,
                     aisState ^ aisPrev_q, rdiState ^ rdiPrev_q};

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rdiPrev_q <= 1'b0;
         aisPrev_q <= 1'b0;
         lineEv_q  <= 4'h0;
      end else begin
         rdiPrev_q <= rdiState;
         aisPrev_q <= aisState;
         lineEv_q  <= (lineEv_q & {4{!rdLineIrq}}) | lineSet;
      end
   end

   a_rdi_event: assert property
      ($changed(rdiState) |=> lineEv_q[LEV_RDI])
      else $error("remote defect change lost");

   logic [6:0] rxScr_q;
   logic [14:0] rxStep;
   logic [7:0] rxPlain;

   assign rxStep  = scrStep(rxFrameStart ? SCR_SEED : rxScr_q);
   assign rxPlain = descrOff ? rxByteIn : rxByteIn ^ rxStep[7:0];

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rxScr_q <= SCR_SEED;
      end else if (rxValid) begin
         rxScr_q <= rxStep[14:8];
      end
   end

   // downstream ones while line alarm declared
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rxDataOut   <= BYTE_ZERO;
         rxDataValid <= 1'b0;
      end else begin
         rxDataValid <= rxValid;
         rxDataOut   <= (forceOnes && aisState) ? BYTE_ONES : rxPlain;
      end
   end

   a_descr_bypass: assert property (rxValid && descrOff
      && !(forceOnes && aisState) |=> rxDataOut == $past(rxByteIn))
      else $error("descrambler bypass altered data");
   a_force_ones: assert property (rxValid && forceOnes && aisState
      |=> rxDataOut == BYTE_ONES)
      else $error("downstream not forced to ones");

   // line alarm insert follows frame boundaries
   logic       aisTxAct_q;
   logic       aisTxEff;
   logic [6:0] txScr_q;
   logic [14:0] txStep;
   logic [7:0] txPre;
   logic [7:0] txScr;

   assign aisTxEff = (txValid && txFrameStart) ? lineAisIns : aisTxAct_q;
   assign txStep   = scrStep(txFrameStart ? SCR_SEED : txScr_q);

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         aisTxAct_q <= 1'b0;
         txScr_q    <= SCR_SEED;
      end else if (txValid) begin
         aisTxAct_q <= aisTxEff;
         txScr_q    <= txStep[14:8];
      end
   end

   always_comb begin
      if (txIsA1) begin
         txPre = txDiag_q[TD_A1_ERROR] ? A1_ERROR : A1_NORMAL;
      end else if (txIsB1) begin
         txPre = txDiag_q[TD_B1_INVERT] ? ~txByteIn : txByteIn;
      end else if (aisTxEff && !txIsSoh) begin
         txPre = BYTE_ONES;
      end else begin
         txPre = txByteIn;
      end
   end

   // scrambler with bypass; framing bytes stay clear
   assign txScr = (scrOff || txIsA1) ? txPre : txPre ^ txStep[7:0];

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         txByteOut   <= BYTE_ZERO;
         txByteValid <= 1'b0;
      end else begin
         txByteValid <= txValid;
         txByteOut   <= txDiag_q[TD_ALL_ZERO] ? BYTE_ZERO : txScr;
      end
   end

   a_tx_zero: assert property (txValid && txDiag_q[TD_ALL_ZERO]
      |=> txByteOut == BYTE_ZERO)
      else $error("all-zero diag not applied");
   a_tx_a1_err: assert property (txValid && txIsA1
      && txDiag_q[TD_A1_ERROR] && !txDiag_q[TD_ALL_ZERO]
      |=> txByteOut == A1_ERROR)
      else $error("A1 error byte not sent");

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         irqOut <= 1'b0;
      end else begin
         irqOut <= |(secEv_q & secCtrl_q[SC_EN_HI:0])
                   || |(lineEv_q & lineEn_q);
      end
   end

   a_irq_gate: assert property (secEv_q[SEV_LOS] && secCtrl_q[SEV_LOS]
      |=> irqOut)
      else $error("enabled section event missed");

   // Read data, one cycle after the strobe
   // live line state
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         regRdData <= 8'h00;
      end else if (regRd) begin
         unique case (regAddr)
            ADR_SEC_CTRL:   regRdData <= secCtrl_q;
            ADR_SEC_STATUS: regRdData <= {1'b0, secEv_q, frmState_q};
            ADR_SEC_CNT_LO: regRdData <= secCount[7:0];
            ADR_SEC_CNT_HI: regRdData <= secCount[15:8];
            ADR_TX_CTRL:    regRdData <= txCtrl_q;
            ADR_TX_DIAG:    regRdData <= {5'h00, txDiag_q};
            ADR_LINE_CTRL:  regRdData <= {lineCtrl_q, aisState, rdiState};
            ADR_LINE_IRQ:   regRdData <= {lineEn_q, lineEv_q};
            default:        regRdData <= 8'h00;
         endcase
      end else begin
         regRdData <= 8'h00;
      end
   end

   a_sec_live: assert property (rdSecStatus
      |=> regRdData[2:0] == $past(frmState_q))
      else $error("section live state misread");
   a_line_live: assert property (regRd && regAddr == ADR_LINE_CTRL
      |=> regRdData[1:0] == $past({aisState, rdiState}))
      else $error("line live state misread");

endmodule

// ==== verif/sloc_far_end.sv ====
// Far-end line element model sending one K2 byte per frame
`timescale 1ns/1ns
module sloc_far_end (
   // Clock
   input  wire logic       clk_sys,
   // Frame control
   input  wire logic [2:0] k2Pat,
   input  wire logic       sendK2,
   // Line side
   output logic [7:0]      k2Byte,
   output logic            k2Valid
);
   initial k2Byte = 8'h00;
   // Between frames the K2 lines do not hold their last value
   always @(posedge clk_sys) begin
      k2Valid <= sendK2;
      k2Byte  <= sendK2 ? {5'h00, k2Pat} : ~k2Byte;
   end
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the overhead control block
`timescale 1ns/1ns
module tb;
   import sloc_pkg::*;
   logic       clk_sys = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, rxByteIn = 8'h00;
   logic [7:0] b1ErrMask = 8'h00, txByteIn = 8'h00;
   logic [7:0] regRdData, txByteOut, k2Byte, rxDataOut;
   logic [19:0] lineB2Count, lineFebeCount;
   logic [4:0] b2ReportCount;
   logic       forceReframe, irqOut, b2ReportValid;
   logic [4:0] b2ErrBits = 5'h00, febeBits = 5'h00;
   logic [2:0] k2Pat = 3'h0;
   logic       rxOofIn = 1'b0, rxLofIn = 1'b0, rxLosIn = 1'b0;
   logic       rxValid = 1'b0, rxFrameStart = 1'b0, b1ErrValid = 1'b0;
   logic       b2ErrValid = 1'b0, febeValid = 1'b0, sendK2 = 1'b0, k2Valid;
   logic       txValid = 1'b0, txFrameStart = 1'b0, txIsSoh = 1'b0;
   logic       txIsA1 = 1'b0, txIsB1 = 1'b0;
   int         mismatches = 0, checked = 0;

   sloc_overhead_ctrl uut (.clk_sys, .rst_b, .regAddr, .regWrData, .regWr,
      .regRd, .regRdData, .rxOofIn, .rxLofIn, .rxLosIn, .forceReframe,
      .framerAlgo2(), .rxByteIn, .rxValid, .rxFrameStart, .rxDataOut,
      .rxDataValid(), .b1ErrMask, .b1ErrValid, .b2ErrBits, .b2ErrValid,
      .febeBits, .febeValid, .k2Byte, .k2Valid, .b2ReportCount,
      .b2ReportValid, .lineB2Count, .lineFebeCount, .txByteIn,
      .txValid, .txFrameStart, .txIsSoh, .txIsA1, .txIsB1, .txByteOut,
      .txByteValid(), .irqOut);
   sloc_far_end far (.clk_sys, .k2Pat, .sendK2, .k2Byte, .k2Valid);

   always #5 clk_sys = ~clk_sys;

   task automatic chk(input string nm, input logic [19:0] e, got);
      checked++;
      if (got !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, d);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [7:0] a, e);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 chk("regRdData", e, regRdData);
      @(posedge clk_sys);
   endtask

   task automatic b1(input int n);
      repeat (n) begin
         b1ErrMask <= 8'h07;
         b1ErrValid <= 1'b1;
         @(posedge clk_sys);
         b1ErrValid <= 1'b0;
         @(posedge clk_sys);
      end
   endtask

   task automatic k2(input logic [2:0] p, input int n);
      k2Pat <= p;
      repeat (n) begin
         sendK2 <= 1'b1;
         @(posedge clk_sys);
         sendK2 <= 1'b0;
         repeat (3) @(posedge clk_sys);
      end
      repeat (2) @(posedge clk_sys);
   endtask

   task automatic tx(input logic a1, input logic [7:0] e);
      txByteIn <= 8'hAB;
      txFrameStart <= 1'b1;
      txIsA1 <= a1;
      txValid <= 1'b1;
      @(posedge clk_sys);
      txValid <= 1'b0;
      #1 chk("txByteOut", e, txByteOut);
      @(posedge clk_sys);
   endtask

   task automatic rx(input logic [7:0] e, input logic f);
      rxByteIn <= 8'h5A;
      rxValid <= 1'b1;
      rxFrameStart <= 1'b1;
      @(posedge clk_sys);
      rxValid <= 1'b0;
      #1 chk("rxDataOut", e, rxDataOut);
      chk("forceReframe", f, forceReframe);
      @(posedge clk_sys);
   endtask

   task automatic err2(input logic [4:0] e);
      b2ErrBits <= 5'h05;
      febeBits <= 5'h03;
      b2ErrValid <= 1'b1;
      febeValid <= 1'b1;
      @(posedge clk_sys);
      b2ErrValid <= 1'b0;
      febeValid <= 1'b0;
      #1 chk("b2ReportCount", e, b2ReportCount);
      chk("b2ReportValid", 1'b1, b2ReportValid);
      @(posedge clk_sys);
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      rd(ADR_SEC_CTRL, 8'h00);
      rd(ADR_TX_CTRL, 8'h00);
      $display("test reset values done");
      wr(ADR_SEC_CTRL, 8'h04);
      rxOofIn <= 1'b1;
      rxLosIn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 chk("irqOut", 1'b1, irqOut);
      @(posedge clk_sys);
      rd(ADR_SEC_STATUS, 8'h2D);
      rd(ADR_SEC_STATUS, 8'h05);
      $display("test section state done");
      b1(1);
      wr(ADR_SEC_CNT_LO, 8'h00);
      rd(ADR_SEC_CNT_LO, 8'h03);
      rd(ADR_SEC_STATUS, 8'h45);
      wr(ADR_SEC_CTRL, 8'h80);
      b1(2);
      wr(ADR_CH_IRQ, 8'h00);
      rd(ADR_SEC_CNT_LO, 8'h02);
      rd(ADR_SEC_CNT_HI, 8'h00);
      b1(1);
      wr(ADR_MASTER, 8'h00);
      rd(ADR_SEC_CNT_LO, 8'h01);
      $display("test section count done");
      wr(ADR_SEC_CTRL, 8'h60);
      rx(8'h5A, 1'b1);
      wr(ADR_SEC_CTRL, 8'h00);
      rx(8'hA4, 1'b0);
      $display("test receive stream done");
      wr(ADR_LINE_IRQ, 8'h20);
      wr(ADR_LINE_CTRL, 8'h60);
      k2(3'h7, 3);
      #1 chk("irqOut", 1'b1, irqOut);
      @(posedge clk_sys);
      rd(ADR_LINE_CTRL, 8'h62);
      rd(ADR_LINE_IRQ, 8'h22);
      rx(8'hFF, 1'b0);
      k2(3'h6, 2);
      rd(ADR_LINE_CTRL, 8'h62);
      k2(3'h6, 1);
      rd(ADR_LINE_CTRL, 8'h60);
      rx(8'hA4, 1'b0);
      k2(3'h6, 2);
      rd(ADR_LINE_CTRL, 8'h61);
      $display("test line alarms done");
      err2(5'h05);
      wr(ADR_LINE_CTRL, 8'h8C);
      err2(5'h01);
      wr(ADR_CH_IRQ, 8'h00);
      chk("lineB2Count", 20'h6, lineB2Count);
      chk("lineFebeCount", 20'h4, lineFebeCount);
      $display("test line counts done");
      wr(ADR_TX_DIAG, 8'h04);
      tx(1'b0, 8'h00);
      wr(ADR_TX_DIAG, 8'h01);
      tx(1'b1, 8'h76);
      wr(ADR_TX_DIAG, 8'h00);
      tx(1'b0, 8'h55);
      wr(ADR_TX_CTRL, 8'h41);
      tx(1'b0, 8'hFF);
      $display("test transmit diag done");
      wrap_up();
   end

   initial begin
      #20000;
      mismatches++;
      wrap_up();
   end
endmodule
